// File: xd_pkg.sv
package xd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PTR_W = 12;
  localparam int OFS_W = 7;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LIT_SUB = 8'h08;
  localparam logic [7:0] OP_PTR_ADD = 8'he8;
  localparam logic [7:0] OP_PTR_SUB = 8'he9;
  localparam logic [7:0] OP_PUSH_LIT = 8'hea;
  localparam logic [7:0] OP_MOVE = 8'heb;
  localparam logic [5:0] EXT_GROUP = 6'h3a;
  localparam logic [3:0] OP_WORD2 = 4'hf;
  localparam logic [15:0] OP_CALL_ACC = 16'h0014;
  localparam logic [1:0] FLD_STACK = 2'h3;
  localparam logic [1:0] IDX_STACK = 2'h2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MOVE_KIND_BIT = 7;
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PTR_W-1:0] PTR_RST = 12'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [1:0] {
    XD_IDLE = 2'b00,
    XD_WORD2 = 2'b01,
    XD_WRITE = 2'b11,
    XD_HOLD = 2'b10
  } xd_state_e;

endpackage

// File: xd_arith_if.sv
interface xd_arith_if;
  import xd_pkg::*;
  logic [7:0] lit;
  logic [7:0] acc;
  logic [PTR_W-1:0] ptr;
  logic [5:0] k;
  logic ptr_sub;
  logic [7:0] diff;
  logic [4:0] flags;
  logic [PTR_W-1:0] ptr_res;
  modport client (output lit, acc, ptr, k, ptr_sub,
                  input diff, flags, ptr_res);
  modport unit (input lit, acc, ptr, k, ptr_sub,
                output diff, flags, ptr_res);
endinterface

// File: xd_arith.sv
module xd_arith
  import xd_pkg::*;
(
  xd_arith_if.unit ar
);

  // ----------------------------------------------------------------
  // literal minus accumulator
  // ----------------------------------------------------------------
  wire [8:0] sum = {1'b0, ar.lit} + {1'b0, ~ar.acc} + 9'h001;
  wire [4:0] nib = {1'b0, ar.lit[3:0]} + {1'b0, ~ar.acc[3:0]} + 5'h01;

  assign ar.diff = sum[7:0];
  assign ar.flags[FLAG_C] = sum[8];
  assign ar.flags[FLAG_DC] = nib[4];
  assign ar.flags[FLAG_Z] = (sum[7:0] == 8'h00);
  assign ar.flags[FLAG_N] = sum[7];
  assign ar.flags[FLAG_OV] = (ar.lit[7] ^ ar.acc[7]) & (sum[7] ^ ar.lit[7]);

  // ----------------------------------------------------------------
  // pointer add or subtract
  // ----------------------------------------------------------------
  wire [PTR_W-1:0] k_ext = {6'h00, ar.k};
  assign ar.ptr_res = ar.ptr_sub ? ar.ptr - k_ext : ar.ptr + k_ext;

endmodule

// File: xd_decoder.sv
// Summary of operation
// - literal minus accumulator writes k-W in one cycle and sets flags.
// - eight extended instructions plus indexed literal offset mode flag.
// - extended set and indexed mode stay off unless the enable bit is set.
// - every extended instruction except call via accumulator changes or addresses through a pointer.
// - add/sub to pointer changes it by 6-bit literal, one cycle, no flags.
// - add with field 11 adds to the third pointer, returns, two cycles.
// - sub with field 11 subtracts from third pointer, returns, two cycles.
// - those stack variants issue their return after the pointer update.
// - call via accumulator, word 0014h, hands over accumulator, 2 cycles.
// - move stack to file writes a stack slot to a 12-bit file address.
// - move stack to stack copies between two third-pointer offsets.
// - store literal and decrement writes at third pointer, then steps it.
module xd_decoder
  import xd_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // configuration
  input wire logic EXT_SET_ENABLE_IN,
  // instruction fetch
  input wire logic INSTR_VALID_IN,
  input wire logic [15:0] INSTR_IN,
  output logic BUSY_OUT,
  // accumulator and status
  input wire logic [7:0] ACC_IN,
  output logic ACC_WE_OUT,
  output logic [7:0] ACC_DATA_OUT,
  output logic FLAGS_WE_OUT,
  output logic [4:0] FLAGS_OUT,
  // data memory
  output logic MEM_RE_OUT,
  output logic MEM_WE_OUT,
  output logic [PTR_W-1:0] MEM_ADDR_OUT,
  output logic [7:0] MEM_WDATA_OUT,
  input wire logic [7:0] MEM_RDATA_IN,
  // program flow
  output logic RETURN_OUT,
  output logic CALL_OUT,
  output logic [7:0] CALL_ACC_OUT,
  // standard decoder hand-off
  output logic STD_OUT,
  output logic [15:0] STD_WORD_OUT,
  output logic INDEXED_MODE_OUT,
  // index pointers
  output logic [PTR_W-1:0] PTR0_OUT,
  output logic [PTR_W-1:0] PTR1_OUT,
  output logic [PTR_W-1:0] PTR2_OUT
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_ext(input logic [15:0] w);
    return (w[15:10] == EXT_GROUP) || (w == OP_CALL_ACC);
  endfunction

  function automatic logic [PTR_W-1:0] stack_addr(
    input logic [PTR_W-1:0] base, input logic [OFS_W-1:0] ofs);
    return base + {5'h00, ofs};
  endfunction

  xd_state_e state_reg, state_next;
  logic ext_en_reg, en_caught_reg, move_ss_reg, ret_pend_reg;
  logic [PTR_W-1:0] dst_reg;
  logic [PTR_W-1:0] ptr_reg [3];
  logic [PTR_W-1:0] ptr_next [3];

  xd_arith_if ar ();
  xd_arith u_arith (.ar(ar));

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [7:0] hi = INSTR_IN[15:8];
  wire [1:0] fld = INSTR_IN[7:6];
  wire take = INSTR_VALID_IN && (state_reg == XD_IDLE);
  wire ext_on = take && ext_en_reg;
  wire do_sub_lit = take && (hi == OP_LIT_SUB);
  wire do_padd = ext_on && (hi == OP_PTR_ADD);
  wire do_psub = ext_on && (hi == OP_PTR_SUB);
  wire do_ptr = do_padd || do_psub;
  wire do_ret = do_ptr && (fld == FLD_STACK);
  wire do_push = ext_on && (hi == OP_PUSH_LIT);
  wire do_move = ext_on && (hi == OP_MOVE);
  wire do_call = ext_on && (INSTR_IN == OP_CALL_ACC);
  wire do_std = take && !do_sub_lit &&
    !(ext_en_reg && is_ext(INSTR_IN));
  wire take2 = INSTR_VALID_IN && (state_reg == XD_WORD2);
  wire word2_ok = take2 && (INSTR_IN[15:12] == OP_WORD2);
  wire [PTR_W-1:0] w2_dst = move_ss_reg ?
    stack_addr(ptr_reg[IDX_STACK], INSTR_IN[OFS_W-1:0]) :
    INSTR_IN[PTR_W-1:0];
  wire [1:0] ptr_idx = do_push ? IDX_STACK :
                       (fld == FLD_STACK) ? IDX_STACK : fld;
  wire [PTR_W-1:0] ptr_dec = ptr_reg[IDX_STACK] - 12'h001;

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  assign ar.lit = INSTR_IN[7:0];
  assign ar.acc = ACC_IN;
  assign ar.ptr = ptr_reg[ptr_idx];
  assign ar.k = INSTR_IN[5:0];
  assign ar.ptr_sub = do_psub;

  // ----------------------------------------------------------------
  // index pointers
  // ----------------------------------------------------------------
  wire ptr_we = do_ptr || do_push;
  wire [PTR_W-1:0] ptr_wdata = do_push ? ptr_dec : ar.ptr_res;
  for (genvar i = 0; i < 3; i++)
  begin : g_ptr
    assign ptr_next[i] = (ptr_we && ptr_idx == 2'(i)) ?
                         ptr_wdata : ptr_reg[i];
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      XD_IDLE:
      begin
        if (do_move)
          state_next = XD_WORD2;
        else if (do_ret || do_call)
          state_next = XD_HOLD;
      end
      XD_WORD2:
      begin
        if (word2_ok)
          state_next = XD_WRITE;
        else if (take2)
          state_next = XD_IDLE;
      end
      XD_WRITE: state_next = XD_IDLE;
      XD_HOLD: state_next = XD_IDLE;
      default: state_next = XD_IDLE;
    endcase
  end

  wire in_write = (state_reg == XD_WRITE);
  wire mem_we_next = do_push || in_write;
  wire [PTR_W-1:0] addr_next = do_push ? ptr_reg[IDX_STACK] :
    do_move ? stack_addr(ptr_reg[IDX_STACK], INSTR_IN[OFS_W-1:0]) :
    dst_reg;
  wire [7:0] wdata_next = do_push ? INSTR_IN[7:0] : MEM_RDATA_IN;
  wire ret_next = (state_reg == XD_HOLD) && ret_pend_reg;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      ext_en_reg <= 1'b0;
      en_caught_reg <= 1'b0;
    end
    else if (!en_caught_reg)
    begin
      ext_en_reg <= EXT_SET_ENABLE_IN;
      en_caught_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      state_reg <= XD_IDLE;
      move_ss_reg <= 1'b0;
      ret_pend_reg <= 1'b0;
      dst_reg <= PTR_RST;
      for (int i = 0; i < 3; i++)
        ptr_reg[i] <= PTR_RST;
    end
    else
    begin
      state_reg <= state_next;
      if (do_move)
        move_ss_reg <= INSTR_IN[MOVE_KIND_BIT];
      if (take)
        ret_pend_reg <= do_ret;
      if (word2_ok)
        dst_reg <= w2_dst;
      ptr_reg <= ptr_next;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      ACC_WE_OUT <= 1'b0;
      ACC_DATA_OUT <= BYTE_RST;
      FLAGS_WE_OUT <= 1'b0;
      FLAGS_OUT <= FLAGS_RST;
      MEM_RE_OUT <= 1'b0;
      MEM_WE_OUT <= 1'b0;
      MEM_ADDR_OUT <= PTR_RST;
      MEM_WDATA_OUT <= BYTE_RST;
      RETURN_OUT <= 1'b0;
      CALL_OUT <= 1'b0;
      CALL_ACC_OUT <= BYTE_RST;
      STD_OUT <= 1'b0;
      STD_WORD_OUT <= WORD_RST;
      BUSY_OUT <= 1'b0;
    end
    else
    begin
      ACC_WE_OUT <= do_sub_lit;
      ACC_DATA_OUT <= ar.diff;
      FLAGS_WE_OUT <= do_sub_lit;
      FLAGS_OUT <= ar.flags;
      MEM_RE_OUT <= do_move;
      MEM_WE_OUT <= mem_we_next;
      MEM_ADDR_OUT <= addr_next;
      MEM_WDATA_OUT <= wdata_next;
      RETURN_OUT <= ret_next;
      CALL_OUT <= do_call;
      CALL_ACC_OUT <= ACC_IN;
      STD_OUT <= do_std;
      STD_WORD_OUT <= INSTR_IN;
      BUSY_OUT <= (state_next != XD_IDLE);
    end
  end

  assign INDEXED_MODE_OUT = ext_en_reg;
  assign PTR0_OUT = ptr_reg[0];
  assign PTR1_OUT = ptr_reg[1];
  assign PTR2_OUT = ptr_reg[2];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  wire [7:0] sub_expect = INSTR_IN[7:0] - ACC_IN;
  wire [PTR_W-1:0] padd_expect = ptr_reg[ptr_idx] + {6'h00, INSTR_IN[5:0]};
  wire [PTR_W-1:0] psub_expect = ptr_reg[ptr_idx] - {6'h00, INSTR_IN[5:0]};
  wire [PTR_W-1:0] p2 = ptr_reg[IDX_STACK];
  wire [PTR_W-1:0] p1 = ptr_reg[1];

  sequence s_ret_after_update;
    !RETURN_OUT ##1 RETURN_OUT ##1 !RETURN_OUT;
  endsequence

  sequence s_move_write;
    !MEM_WE_OUT ##1 MEM_WE_OUT;
  endsequence

  a_sub_lit_result: assert property (
    do_sub_lit |=> ACC_WE_OUT && FLAGS_WE_OUT &&
    ACC_DATA_OUT == $past(sub_expect))
    else $error("literal subtract result wrong");
  a_sub_lit_zero: assert property (
    do_sub_lit && INSTR_IN[7:0] == ACC_IN |=>
    FLAGS_OUT[FLAG_Z] && FLAGS_OUT[FLAG_C])
    else $error("literal subtract zero flags wrong");
  a_disabled_std: assert property (
    take && !ext_en_reg && is_ext(INSTR_IN) |=>
    STD_OUT && !MEM_WE_OUT && !CALL_OUT && !BUSY_OUT)
    else $error("extended opcode ran while disabled");
  a_ptr_add_one: assert property (
    do_padd && fld == 2'h1 |=>
    p1 == $past(padd_expect) && !FLAGS_WE_OUT && !BUSY_OUT)
    else $error("pointer add wrong");
  a_ptr_sub_stack: assert property (
    do_psub && fld == FLD_STACK |=> p2 == $past(psub_expect))
    else $error("stack pointer subtract wrong");
  a_stack_return: assert property (
    do_ret |=> s_ret_after_update)
    else $error("return not one cycle after update");
  a_call_acc: assert property (
    do_call |=> CALL_OUT && CALL_ACC_OUT == $past(ACC_IN) && BUSY_OUT
    ##1 !BUSY_OUT)
    else $error("call via accumulator wrong");
  a_push_lit: assert property (
    do_push |=> MEM_WE_OUT && MEM_ADDR_OUT == $past(p2) &&
    p2 == $past(ptr_dec))
    else $error("literal push wrong");
  a_move_file: assert property (
    word2_ok && !move_ss_reg |=> s_move_write ##0
    MEM_ADDR_OUT == $past(INSTR_IN[PTR_W-1:0], 2))
    else $error("stack to file write wrong");
  a_move_stack: assert property (
    do_move |=> MEM_RE_OUT &&
    MEM_ADDR_OUT == $past(p2) + {5'h00, $past(INSTR_IN[OFS_W-1:0])})
    else $error("stack move source wrong");
  a_enable_latch: assert property (
    $rose(en_caught_reg) |-> INDEXED_MODE_OUT == $past(EXT_SET_ENABLE_IN))
    else $error("extended mode not taken from enable");

endmodule

// File: testbench.sv
module testbench
  import xd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // signals and bench state
  // ----------------------------------------------------------------
  logic CLK_IN = 1'b0;
  logic RESETN_IN = 1'b0;
  logic EXT_SET_ENABLE_IN = 1'b0;
  logic INSTR_VALID_IN = 1'b0;
  logic [15:0] INSTR_IN = 16'h0000;
  logic [7:0] ACC_IN = 8'h00;
  logic [7:0] MEM_RDATA_IN = 8'h00;
  logic BUSY_OUT, ACC_WE_OUT, FLAGS_WE_OUT, MEM_RE_OUT, MEM_WE_OUT;
  logic RETURN_OUT, CALL_OUT, STD_OUT, INDEXED_MODE_OUT;
  logic [7:0] ACC_DATA_OUT, MEM_WDATA_OUT, CALL_ACC_OUT;
  logic [4:0] FLAGS_OUT;
  logic [15:0] STD_WORD_OUT;
  logic [PTR_W-1:0] MEM_ADDR_OUT, PTR0_OUT, PTR1_OUT, PTR2_OUT;
  logic [PTR_W-1:0] p [3];
  logic [PTR_W-1:0] prev [3];
  logic [27:0] exp_q [$];
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;

  xd_decoder u_xd_decoder (
    .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
    .EXT_SET_ENABLE_IN(EXT_SET_ENABLE_IN),
    .INSTR_VALID_IN(INSTR_VALID_IN), .INSTR_IN(INSTR_IN),
    .BUSY_OUT(BUSY_OUT), .ACC_IN(ACC_IN), .ACC_WE_OUT(ACC_WE_OUT),
    .ACC_DATA_OUT(ACC_DATA_OUT), .FLAGS_WE_OUT(FLAGS_WE_OUT),
    .FLAGS_OUT(FLAGS_OUT), .MEM_RE_OUT(MEM_RE_OUT),
    .MEM_WE_OUT(MEM_WE_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT),
    .MEM_WDATA_OUT(MEM_WDATA_OUT), .MEM_RDATA_IN(MEM_RDATA_IN),
    .RETURN_OUT(RETURN_OUT), .CALL_OUT(CALL_OUT),
    .CALL_ACC_OUT(CALL_ACC_OUT), .STD_OUT(STD_OUT),
    .STD_WORD_OUT(STD_WORD_OUT), .INDEXED_MODE_OUT(INDEXED_MODE_OUT),
    .PTR0_OUT(PTR0_OUT), .PTR1_OUT(PTR1_OUT), .PTR2_OUT(PTR2_OUT)
  );

  always #25 CLK_IN = ~CLK_IN;

  // ----------------------------------------------------------------
  // compare, verdict and hang guard
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      err_total++;
    end
  endtask

  always @(posedge CLK_IN)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // output watcher: each result takes the oldest note
  // ----------------------------------------------------------------
  function automatic logic [27:0] pop();
    if (exp_q.size() == 0)
      return 28'hfffffff;
    return exp_q.pop_front();
  endfunction

  function automatic logic [PTR_W-1:0] cur(input int i);
    return i == 0 ? PTR0_OUT : i == 1 ? PTR1_OUT : PTR2_OUT;
  endfunction

  always @(negedge CLK_IN)
  begin
    if (RESETN_IN)
    begin
      if (ACC_WE_OUT || FLAGS_WE_OUT)
        check({4'h1, ACC_WE_OUT, FLAGS_WE_OUT, 9'h0, FLAGS_OUT,
               ACC_DATA_OUT}, pop());
      if (MEM_RE_OUT)
        check({4'h6, 12'h0, MEM_ADDR_OUT}, pop());
      if (MEM_WE_OUT)
        check({4'h2, 4'h0, MEM_ADDR_OUT, MEM_WDATA_OUT}, pop());
      for (int i = 0; i < 3; i++)
        if (cur(i) !== prev[i])
          check({4'h7, 10'h0, 2'(i), cur(i)}, pop());
      if (RETURN_OUT)
        check({4'h3, 12'h0, PTR2_OUT}, pop());
      if (CALL_OUT)
        check({4'h4, 16'h0, CALL_ACC_OUT}, pop());
      if (STD_OUT)
        check({4'h5, 8'h0, STD_WORD_OUT}, pop());
    end
    for (int i = 0; i < 3; i++)
      prev[i] = cur(i);
  end

  // ----------------------------------------------------------------
  // drivers with their expectations
  // ----------------------------------------------------------------
  task automatic note(input logic [3:0] k, input logic [23:0] pl);
    exp_q.push_back({k, pl});
  endtask

  task automatic issue(input logic [15:0] w);
    INSTR_IN = w;
    INSTR_VALID_IN = 1'b1;
    @(posedge CLK_IN) #2;
  endtask

  task automatic idle(input int n);
    INSTR_VALID_IN = 1'b0;
    repeat (n) @(posedge CLK_IN) #2;
  endtask

  task automatic rst(input int n, input logic en);
    RESETN_IN = 1'b0;
    EXT_SET_ENABLE_IN = en;
    INSTR_VALID_IN = 1'b0;
    p = '{default: 12'h000};
    repeat (n) @(posedge CLK_IN) #2;
    RESETN_IN = 1'b1;
    idle(2);
    check({24'h0, PTR0_OUT == 12'h0, PTR1_OUT == 12'h0, PTR2_OUT == 12'h0,
           INDEXED_MODE_OUT}, {24'h0, 3'b111, en});
  endtask

  task automatic lsub(input logic [7:0] k, input logic [7:0] w);
    logic [7:0] r;
    logic [4:0] f;
    r = k - w;
    f = {r[7], (k[7] != w[7]) && (r[7] != k[7]), r == 8'h00,
         k[3:0] >= w[3:0], k >= w};
    ACC_IN = w;
    note(4'h1, {2'b11, 9'h0, f, r});
    issue({8'h08, k});
  endtask

  task automatic ptr_op(input logic s, input logic [1:0] f,
                        input logic [5:0] k, input logic junk);
    int ix;
    ix = (f == 2'h3) ? 2 : int'(f);
    p[ix] = s ? p[ix] - {6'h0, k} : p[ix] + {6'h0, k};
    note(4'h7, {10'h0, 2'(ix), p[ix]});
    if (f == 2'h3)
      note(4'h3, {12'h0, p[2]});
    issue({7'h74, s, f, k});
    if (f == 2'h3 && junk)
      issue(16'hea55);
    if (f == 2'h3)
      idle(1);
  endtask

  task automatic push(input logic [7:0] k);
    note(4'h2, {4'h0, p[2], k});
    p[2] = p[2] - 12'h001;
    note(4'h7, {10'h0, 2'h2, p[2]});
    issue({8'hea, k});
  endtask

  task automatic move(input logic kind, input logic [6:0] z,
                      input logic [11:0] a, input int gap, input logic ab);
    logic [7:0] rd;
    logic [11:0] dst;
    rd = 8'($urandom);
    dst = kind ? p[2] + {5'h0, a[6:0]} : a;
    note(4'h6, {12'h0, p[2] + {5'h0, z}});
    if (!ab)
      note(4'h2, {4'h0, dst, rd});
    issue({8'heb, kind, z});
    MEM_RDATA_IN = rd;
    if (gap > 0)
      idle(gap);
    issue({ab ? 4'h3 : 4'hf, a});
    idle(2);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [15:0] ext_w [5];
    ext_w = '{16'he841, 16'he9c2, 16'hea5a, 16'heb03, 16'h0014};
    void'($urandom(56928));
    rst(20, 1'b0);
    foreach (ext_w[i])
    begin
      note(4'h5, {8'h0, ext_w[i]});
      issue(ext_w[i]);
    end
    lsub(8'h02, 8'h01);
    idle(3);
    rst(2, 1'b1);
    lsub(8'h02, 8'h01);
    lsub(8'h02, 8'h02);
    lsub(8'h02, 8'h03);
    lsub(8'h80, 8'h01);
    lsub(8'h00, 8'h80);
    note(4'h5, {8'h0, 16'hec5a});
    issue(16'hec5a);
    repeat (20)
      lsub(8'($urandom), 8'($urandom));
    for (int f = 0; f < 4; f++)
      for (int s = 0; s < 2; s++)
        ptr_op(s[0], 2'(f), 6'($urandom_range(1, 63)), 1'b0);
    ptr_op(1'b1, 2'h0, 6'h3f, 1'b0);
    ptr_op(1'b0, 2'h1, 6'h3f, 1'b0);
    ptr_op(1'b0, 2'h3, 6'h01, 1'b1);
    repeat (3)
      push(8'($urandom));
    ACC_IN = 8'($urandom);
    note(4'h4, {16'h0, ACC_IN});
    issue(16'h0014);
    check({27'h0, BUSY_OUT}, 28'h1);
    idle(1);
    move(1'b0, 7'h7f, 12'hfff, 0, 1'b0);
    move(1'b1, 7'($urandom), 12'h07f, 2, 1'b0);
    move(1'b0, 7'h05, 12'h123, 0, 1'b1);
    move(1'b1, 7'h00, 12'h001, 0, 1'b0);
    lsub(8'($urandom), 8'($urandom));
    idle(4);
    check(28'(exp_q.size()), 28'h0);
    end_sim();
  end
endmodule
